// *** bio_defines.svh ***
// Register offsets, widths and reset values of the bidirectional I/O ports
// Assumes a data-memory address bus of eight bits from the processor core
`ifndef BIO_DEFINES_SVH
`define BIO_DEFINES_SVH
`define BIO_ADDR_W 8
`define BIO_OFF_A_DATA 8'h12
`define BIO_OFF_A_DIR 8'h13
`define BIO_OFF_B_DATA 8'h14
`define BIO_OFF_B_DIR 8'h15
`define BIO_A_PINS 8
`define BIO_B_PINS 4
`define BIO_DIR_RESET 8'hff
`define BIO_LATCH_RESET 8'hff
`define BIO_DIR_INPUT 1'b1
`define BIO_RDATA_RESET 8'h00
`define BIO_UNMAPPED_RDATA 8'h00
`define BIO_PAD_PREV_RESET 8'hff
`endif

// *** bio_pkg.sv ***
// Types shared by the bidirectional I/O port block
// Assumes bio_defines.svh sits in the include path
`default_nettype none
package bio_pkg;
    typedef logic [7:0] bio_byte_t;
    typedef enum logic [1:0] {
        BIO_OP_WRITE = 2'b00,
        BIO_OP_SET = 2'b01,
        BIO_OP_CLR = 2'b11,
        BIO_OP_CPL = 2'b10
    } bio_op_e;
    typedef struct packed {
        logic wr;
        bio_op_e op;
        logic [2:0] bit_sel;
        logic [7:0] addr;
        bio_byte_t wdata;
    } bio_req_s;
endpackage
`default_nettype wire

// *** bio_ports.sv ***
// Two general purpose ports: port A eight pins, port B four pins
// Assumes the core presents one access per cycle, pads are synchronous inputs
`include "bio_defines.svh"
`default_nettype none
module bio_ports
    import bio_pkg::*;
#(
    parameter int A_PINS = `BIO_A_PINS,
    parameter int B_PINS = `BIO_B_PINS,
    parameter bit PULL_HIGH_OPT = 1'b1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire bio_req_s req,
    input wire logic rd,
    input wire logic halted,
    input wire logic [11:0] pad_in,
    output logic [11:0] pad_out,
    output logic [11:0] pad_oe,
    output logic [11:0] pad_pullup,
    output logic [7:0] rdata_r,
    output logic wake_r
);
    // Only eight port A pins and one to four port B pins are wired
    if (A_PINS != `BIO_A_PINS || B_PINS < 1 || B_PINS > `BIO_B_PINS) begin : g_bad_pins
        $error("Unsupported pin counts");
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    localparam logic [7:0] B_MASK = 8'(((1 << B_PINS) - 1));
    logic [7:0] a_lat_r, a_dir_r, b_lat_r, b_dir_r;
    logic [7:0] a_view, b_view, cur, mod_nxt, pad_oe_r, pad_out_r, pull_r;
    logic [3:0] pad_oe_b_r, pad_out_b_r, pull_b_r;
    logic [7:0] a_pad_prev_r;
    logic a_prev_valid_r;

    // Read-back: pad for inputs, latch for outputs
    assign a_view = (a_dir_r & pad_in[7:0]) | (~a_dir_r & a_lat_r);
    assign b_view = ((b_dir_r & {4'h0, pad_in[11:8]}) | (~b_dir_r & b_lat_r)) & B_MASK;

    // Read-modify-write source and result
    always_comb begin
        cur = (req.addr == `BIO_OFF_B_DATA) ? b_view : a_view;
        case (req.op)
            BIO_OP_WRITE: mod_nxt = req.wdata;
            BIO_OP_SET: mod_nxt = cur | (8'h01 << req.bit_sel);
            BIO_OP_CLR: mod_nxt = cur & ~(8'h01 << req.bit_sel);
            BIO_OP_CPL: mod_nxt = ~cur;
            default: mod_nxt = req.wdata;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            a_lat_r <= `BIO_LATCH_RESET;
            b_lat_r <= `BIO_LATCH_RESET & B_MASK;
        end else if (req.wr) begin
            if (req.addr == `BIO_OFF_A_DATA) begin
                a_lat_r <= mod_nxt;
            end else if (req.addr == `BIO_OFF_B_DATA) begin
                b_lat_r <= mod_nxt & B_MASK;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            a_dir_r <= `BIO_DIR_RESET;
            b_dir_r <= `BIO_DIR_RESET & B_MASK;
        end else if (req.wr && req.op == BIO_OP_WRITE) begin
            if (req.addr == `BIO_OFF_A_DIR) begin
                a_dir_r <= req.wdata;
            end else if (req.addr == `BIO_OFF_B_DIR) begin
                b_dir_r <= req.wdata & B_MASK;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= `BIO_RDATA_RESET;
        end else if (rd) begin
            case (req.addr)
                `BIO_OFF_A_DATA: rdata_r <= a_view;
                `BIO_OFF_A_DIR: rdata_r <= a_dir_r;
                `BIO_OFF_B_DATA: rdata_r <= b_view;
                `BIO_OFF_B_DIR: rdata_r <= b_dir_r;
                default: rdata_r <= `BIO_UNMAPPED_RDATA;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin drive, registered from the next register state
    // ----------------------------------------------------------------
    logic [7:0] a_lat_nxt, a_dir_nxt, b_lat_nxt, b_dir_nxt;
    always_comb begin
        a_lat_nxt = a_lat_r;
        b_lat_nxt = b_lat_r;
        a_dir_nxt = a_dir_r;
        b_dir_nxt = b_dir_r;
        if (req.wr) begin
            if (req.addr == `BIO_OFF_A_DATA) a_lat_nxt = mod_nxt;
            if (req.addr == `BIO_OFF_B_DATA) b_lat_nxt = mod_nxt & B_MASK;
            if (req.op == BIO_OP_WRITE && req.addr == `BIO_OFF_A_DIR) a_dir_nxt = req.wdata;
            if (req.op == BIO_OP_WRITE && req.addr == `BIO_OFF_B_DIR) begin
                b_dir_nxt = req.wdata & B_MASK;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pad_oe_r <= 8'h00;
            pad_out_r <= 8'h00;
            pull_r <= PULL_HIGH_OPT ? 8'hff : 8'h00;
            pad_oe_b_r <= 4'h0;
            pad_out_b_r <= 4'h0;
            pull_b_r <= PULL_HIGH_OPT ? 4'hf : 4'h0;
        end else begin
            pad_oe_r <= ~a_dir_nxt;
            pad_out_r <= a_lat_nxt & ~a_dir_nxt;
            pull_r <= PULL_HIGH_OPT ? a_dir_nxt : 8'h00;
            pad_oe_b_r <= ~b_dir_nxt[3:0] & B_MASK[3:0];
            pad_out_b_r <= b_lat_nxt[3:0] & ~b_dir_nxt[3:0];
            pull_b_r <= PULL_HIGH_OPT ? (b_dir_nxt[3:0] & B_MASK[3:0]) : 4'h0;
        end
    end
    assign pad_oe = {pad_oe_b_r, pad_oe_r};
    assign pad_out = {pad_out_b_r, pad_out_r};
    assign pad_pullup = {pull_b_r, pull_r};

    // ----------------------------------------------------------------
    // Wake-up on any change of a port A pin while halted
    // ----------------------------------------------------------------
    // The first cycle after reset has no earlier sample, so no false edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            a_pad_prev_r <= `BIO_PAD_PREV_RESET;
            a_prev_valid_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            a_pad_prev_r <= pad_in[7:0];
            a_prev_valid_r <= 1'b1;
            wake_r <= halted && a_prev_valid_r && (pad_in[7:0] != a_pad_prev_r);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_wr_a;
        @(posedge sys_clk) disable iff (!nrst)
        req.wr && req.op == BIO_OP_WRITE && req.addr == `BIO_OFF_A_DATA
            |=> a_lat_r == $past(req.wdata);
    endproperty
    a_wr_a: assert property (p_wr_a) else $error("Port A latch not written");

    property p_hold;
        @(posedge sys_clk) disable iff (!nrst)
        !(req.wr && req.addr == `BIO_OFF_A_DATA) |=> $stable(a_lat_r);
    endproperty
    a_hold: assert property (p_hold) else $error("Port A latch changed unwritten");

    property p_dir;
        @(posedge sys_clk) disable iff (!nrst)
        req.wr && req.op == BIO_OP_WRITE && req.addr == `BIO_OFF_B_DIR
            |=> b_dir_r == ($past(req.wdata) & B_MASK);
    endproperty
    a_dir: assert property (p_dir) else $error("Port B direction wrong");

    property p_oe;
        @(posedge sys_clk) disable iff (!nrst)
        ##1 pad_oe[7:0] == ~a_dir_r;
    endproperty
    a_oe: assert property (p_oe) else $error("Drive enable mismatches direction");

    property p_pull;
        @(posedge sys_clk) disable iff (!nrst)
        ##1 pad_pullup[7:0] == (PULL_HIGH_OPT ? a_dir_r : 8'h00);
    endproperty
    a_pull: assert property (p_pull) else $error("Pull-up mismatches direction");

    property p_rd;
        @(posedge sys_clk) disable iff (!nrst)
        rd && req.addr == `BIO_OFF_A_DATA |=> rdata_r == $past(a_view);
    endproperty
    a_rd: assert property (p_rd) else $error("Port A read-back wrong");

    property p_set;
        @(posedge sys_clk) disable iff (!nrst)
        req.wr && req.op == BIO_OP_SET && req.addr == `BIO_OFF_A_DATA
            |=> a_lat_r[$past(req.bit_sel)] == 1'b1;
    endproperty
    a_set: assert property (p_set) else $error("Bit set failed");

    property p_cpl;
        @(posedge sys_clk) disable iff (!nrst)
        req.wr && req.op == BIO_OP_CPL && req.addr == `BIO_OFF_A_DATA
            |=> a_lat_r == ~$past(a_view);
    endproperty
    a_cpl: assert property (p_cpl) else $error("Complement failed");

    property p_bz;
        @(posedge sys_clk) disable iff (!nrst)
        ((b_lat_r | b_dir_r) & ~B_MASK) == 8'h00;
    endproperty
    a_bz: assert property (p_bz) else $error("Port B upper bits set");

    property p_wake;
        @(posedge sys_clk) disable iff (!nrst)
        halted && a_prev_valid_r && pad_in[7:0] != a_pad_prev_r |=> wake_r;
    endproperty
    a_wake: assert property (p_wake) else $error("Missed wake-up");

    property p_clr;
        @(posedge sys_clk) disable iff (!nrst)
        req.wr && req.op == BIO_OP_CLR && req.addr == `BIO_OFF_A_DATA
            |=> a_lat_r[$past(req.bit_sel)] == 1'b0;
    endproperty
    a_clr: assert property (p_clr) else $error("Bit clear failed");

    property p_set_keep;
        @(posedge sys_clk) disable iff (!nrst)
        req.wr && req.op == BIO_OP_SET && req.addr == `BIO_OFF_A_DATA
            |=> (a_lat_r | (8'h01 << $past(req.bit_sel)))
                == ($past(a_view) | (8'h01 << $past(req.bit_sel)));
    endproperty
    a_set_keep: assert property (p_set_keep) else $error("Bit set hit other bits");

    property p_wr_b;
        @(posedge sys_clk) disable iff (!nrst)
        req.wr && req.op == BIO_OP_WRITE && req.addr == `BIO_OFF_B_DATA
            |=> b_lat_r == ($past(req.wdata) & B_MASK);
    endproperty
    a_wr_b: assert property (p_wr_b) else $error("Port B latch not written");

    property p_dir_a;
        @(posedge sys_clk) disable iff (!nrst)
        req.wr && req.op == BIO_OP_WRITE && req.addr == `BIO_OFF_A_DIR
            |=> a_dir_r == $past(req.wdata);
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("Port A direction wrong");

    property p_dir_hold;
        @(posedge sys_clk) disable iff (!nrst)
        !(req.wr && req.op == BIO_OP_WRITE && req.addr == `BIO_OFF_A_DIR)
            |=> $stable(a_dir_r);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("Port A direction changed");

    property p_out;
        @(posedge sys_clk) disable iff (!nrst)
        pad_out[7:0] == (a_lat_r & ~a_dir_r);
    endproperty
    a_out: assert property (p_out) else $error("Pin drive mismatches latch");

    property p_rd_b;
        @(posedge sys_clk) disable iff (!nrst)
        rd && req.addr == `BIO_OFF_B_DATA |=> rdata_r == $past(b_view);
    endproperty
    a_rd_b: assert property (p_rd_b) else $error("Port B read-back wrong");

    property p_rd_dir;
        @(posedge sys_clk) disable iff (!nrst)
        rd && req.addr == `BIO_OFF_A_DIR |=> rdata_r == $past(a_dir_r);
    endproperty
    a_rd_dir: assert property (p_rd_dir) else $error("Direction read-back wrong");

    property p_rd_none;
        @(posedge sys_clk) disable iff (!nrst)
        rd && (req.addr < `BIO_OFF_A_DATA || req.addr > `BIO_OFF_B_DIR)
            |=> rdata_r == `BIO_UNMAPPED_RDATA;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("Unmapped read not zero");

    property p_rd_hold;
        @(posedge sys_clk) disable iff (!nrst)
        !rd |=> $stable(rdata_r);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("Read data changed unread");

    property p_quiet;
        @(posedge sys_clk) disable iff (!nrst)
        !halted |=> !wake_r;
    endproperty
    a_quiet: assert property (p_quiet) else $error("Wake-up while running");

    property p_b_hold;
        @(posedge sys_clk) disable iff (!nrst)
        !(req.wr && req.addr == `BIO_OFF_B_DATA) |=> $stable(b_lat_r);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("Port B latch changed unwritten");
endmodule
`default_nettype wire

// *** bio_pins_model.sv ***
// Board-side model of the twelve port pins
// Assumes pad_oe high means the port itself drives the pin
`default_nettype none
module bio_pins_model (
    input wire logic sys_clk,
    input wire logic [11:0] pad_out,
    input wire logic [11:0] pad_oe,
    input wire logic [11:0] pad_pullup,
    input wire logic [11:0] ext_en,
    input wire logic [11:0] ext_val,
    output logic [11:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] last_r = 12'h000;
    // Floating pins flip every cycle so no stale level survives
    always_ff @(posedge sys_clk) last_r <= pad_in;
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (pad_oe[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad_pullup[i]) pad_in[i] = 1'b1;
            else pad_in[i] = ~last_r[i];
        end
    end
endmodule
`default_nettype wire

// *** bidirectional_io_ports_tb.sv ***
// Self-checking bench of the two general purpose ports
// Assumes bio_pkg compiled first and bio_defines.svh in the include path
`include "bio_defines.svh"
`default_nettype none
module bidirectional_io_ports_tb
    import bio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, nrst, rd, halted;
    bio_req_s req;
    logic [11:0] ext_en, ext_val, pad_in, pad_out, pad_oe, pad_pullup;
    logic [7:0] rdata_r;
    logic wake_r;
    int err_count, samples_checked;
    bio_byte_t lat [2];
    bio_byte_t dir [2];
    bio_ports #(.PULL_HIGH_OPT(1'b1)) u_bio_ports (.sys_clk(sys_clk), .nrst(nrst), .req(req),
        .rd(rd), .halted(halted), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .rdata_r(rdata_r), .wake_r(wake_r));
    bio_pins_model u_bio_pins_model (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    always #5 sys_clk = ~sys_clk;
    function automatic bio_byte_t msk(int p);
        return p ? 8'h0f : 8'hff;
    endfunction
    // Expected read-back: pad for input bits, latch for output bits
    function automatic bio_byte_t rb(int p);
        bio_byte_t pad;
        logic [11:0] lvl;
        // Released input pins sit at their pull-up level
        lvl = (ext_val & ext_en) | ~ext_en;
        pad = p ? {4'h0, lvl[11:8]} : lvl[7:0];
        return ((dir[p] & pad) | (~dir[p] & lat[p])) & msk(p);
    endfunction
    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize;
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input bio_op_e op, input bio_byte_t a, input logic [2:0] b,
                      input bio_byte_t d);
        int p;
        bio_byte_t v;
        logic [11:0] dv;
        p = (a >= `BIO_OFF_B_DATA) ? 1 : 0;
        case (op)
            BIO_OP_WRITE: v = d;
            BIO_OP_SET: v = rb(p) | (8'h01 << b);
            BIO_OP_CLR: v = rb(p) & ~(8'h01 << b);
            default: v = ~rb(p);
        endcase
        @(posedge sys_clk);
        req <= '{wr: 1'b1, op: op, bit_sel: b, addr: a, wdata: d};
        @(posedge sys_clk);
        req.wr <= 1'b0;
        if (a == `BIO_OFF_A_DATA || a == `BIO_OFF_B_DATA) lat[p] = v & msk(p);
        if ((a == `BIO_OFF_A_DIR || a == `BIO_OFF_B_DIR) && op == BIO_OP_WRITE) begin
            dir[p] = d & msk(p);
        end
        dv = {dir[1][3:0], dir[0]};
        #1;
        chk(pad_oe, ~dv, "oe");
        chk(pad_out & ~dv, {lat[1][3:0], lat[0]} & ~dv, "out");
        chk(pad_pullup, dv, "pull");
    endtask
    task automatic rdc(input bio_byte_t a);
        int p;
        bio_byte_t e;
        p = (a >= `BIO_OFF_B_DATA) ? 1 : 0;
        if (a == `BIO_OFF_A_DATA || a == `BIO_OFF_B_DATA) e = rb(p);
        else if (a == `BIO_OFF_A_DIR || a == `BIO_OFF_B_DIR) e = dir[p];
        else e = 8'h00;
        @(posedge sys_clk);
        req.addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk({4'h0, rdata_r}, {4'h0, e}, "read");
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        summarize();
    end
    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        req = '0;
        rd = 1'b0;
        halted = 1'b0;
        ext_en = 12'hfff;
        ext_val = 12'ha5c;
        err_count = 0;
        samples_checked = 0;
        lat = '{8'hff, 8'h0f};
        dir = '{8'hff, 8'h0f};
        void'($urandom(56));
        repeat (10) @(posedge sys_clk);
        chk(pad_oe, 12'h000, "rst oe");
        chk(pad_pullup, 12'hfff, "rst pull");
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) rdc(8'h12 + i[7:0]);
        wr(BIO_OP_WRITE, 8'h13, 3'h0, 8'h0f);
        wr(BIO_OP_WRITE, 8'h12, 3'h0, 8'h55);
        wr(BIO_OP_SET, 8'h12, 3'h7, 8'h00);
        wr(BIO_OP_SET, 8'h13, 3'h7, 8'h00);
        wr(BIO_OP_WRITE, 8'h15, 3'h0, 8'hf5);
        wr(BIO_OP_WRITE, 8'h14, 3'h0, 8'hff);
        rdc(8'h12);
        rdc(8'h14);
        @(posedge sys_clk);
        ext_en <= 12'h0f0;
        @(posedge sys_clk);
        rdc(8'h12);
        rdc(8'h14);
        @(posedge sys_clk);
        ext_en <= 12'hfff;
        for (int i = 0; i < 300; i++) begin
            @(posedge sys_clk);
            ext_val <= 12'($urandom);
            @(posedge sys_clk);
            wr(bio_op_e'($urandom_range(0, 3)), 8'h12 + 8'($urandom_range(0, 4)),
               3'($urandom), 8'($urandom));
            rdc(8'h12 + 8'($urandom_range(0, 4)));
        end
        wr(BIO_OP_WRITE, 8'h13, 3'h0, 8'hff);
        @(posedge sys_clk);
        halted <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk({11'h0, wake_r}, 12'h000, "idle wake");
        @(posedge sys_clk);
        ext_val[5] <= ~ext_val[5];
        for (int n = 0; n <= 4; n++) begin
            @(posedge sys_clk);
            #1;
            if (wake_r === 1'b1) break;
            if (n == 4) chk({11'h0, wake_r}, 12'h001, "no wake");
        end
        // Second reset in mid-run: pins fall back to pulled inputs
        @(posedge sys_clk);
        nrst <= 1'b0;
        halted <= 1'b0;
        lat = '{8'hff, 8'h0f};
        dir = '{8'hff, 8'h0f};
        @(posedge sys_clk);
        #1;
        chk(pad_oe, 12'h000, "rst2 oe");
        chk(pad_pullup, 12'hfff, "rst2 pull");
        @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) rdc(8'h12 + i[7:0]);
        summarize();
    end
endmodule
`default_nettype wire
